/* pkg/sfr_pkg.sv */
// Constants and types shared by the serial flash read engine.
// Assumes all users import the whole package.
package sfr_pkg;

    // Geometry of the main array and the two data buffers
    localparam int unsigned ARR_PAGES = 32'h400;
    localparam int unsigned PAGE_BYTES = 32'h108;
    localparam int unsigned BUF_BYTES = 32'h108;
    localparam int unsigned PAGE_AW = 32'hA;
    localparam int unsigned BYTE_AW = 32'h9;
    localparam int unsigned ARR_AW = 32'h13;
    localparam int unsigned DATA_W = 32'h8;
    localparam int unsigned ARR_DEPTH = ARR_PAGES * PAGE_BYTES;
    localparam logic [8:0] PAGE_LAST_BYTE = 9'h107;
    localparam logic [8:0] BUF_LAST_BYTE = 9'h107;
    localparam logic [9:0] LAST_PAGE = 10'h3FF;

    // Opcodes with the family bit removed; bit 7 set selects SPI mode 0/3
    localparam int unsigned OP_FAMILY_BIT = 32'h7;
    localparam logic [6:0] OP_ARR_CONT = 7'h68;
    localparam logic [6:0] OP_PAGE = 7'h52;
    localparam logic [6:0] OP_BUF1 = 7'h54;
    localparam logic [6:0] OP_BUF2 = 7'h56;
    localparam logic [6:0] OP_STATUS = 7'h57;

    // Header lengths in serial clocks, counted from chip select falling
    localparam logic [6:0] OPCODE_BITS = 7'h08;
    localparam logic [6:0] ADDR_DONE_BITS = 7'h20;
    localparam logic [6:0] HDR_ARR = 7'h40;
    localparam logic [6:0] HDR_BUF = 7'h28;
    localparam logic [6:0] HDR_STAT = 7'h08;

    // Field positions inside the 32 bits received first
    localparam int unsigned PAGE_LSB = 32'h9;
    localparam int unsigned BYTE_LSB = 32'h0;

    // Status byte layout
    localparam int unsigned ST_READY_BIT = 32'h7;
    localparam int unsigned ST_CMP_BIT = 32'h6;
    localparam int unsigned ST_INFO_LSB = 32'h3;
    localparam logic [2:0] ST_RSVD_VAL = 3'h0;

    // Pin sampler lanes and their reset levels
    localparam int unsigned PIN_CS = 32'h0;
    localparam int unsigned PIN_SCK = 32'h1;
    localparam int unsigned PIN_SI = 32'h2;
    localparam int unsigned PIN_CNT = 32'h3;
    localparam logic [2:0] PIN_RST_VAL = 3'h1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR = 4'h2,
        ST_DATA = 4'h4,
        ST_DISCARD = 4'h8
    } sfr_state_e;

    typedef enum logic [2:0] {
        SRC_ARR = 3'h0,
        SRC_PAGE = 3'h1,
        SRC_BUF1 = 3'h2,
        SRC_BUF2 = 3'h3,
        SRC_STAT = 3'h4,
        SRC_NONE = 3'h7
    } sfr_src_e;

endpackage : sfr_pkg

/* verilog/sfr_sync.sv */
// Three-stage pin sampler with agreement filter and edge pulses.
// Assumes the pin is asynchronous to mclk.
`timescale 1ns/1ns
module sfr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Pin and filtered result
    input wire logic pin,
    output logic lvl,
    output logic rise,
    output logic fall
);
    logic ff1_q;
    logic ff2_q;
    logic ff3_q;
    logic lvl_q;
    logic rise_q;
    logic fall_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ff1_q <= RST_VAL;
            ff2_q <= RST_VAL;
            ff3_q <= RST_VAL;
        end
        else
        begin
            ff1_q <= pin;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // A change counts once the second and third stage agree
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lvl_q <= RST_VAL;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            if (ff2_q == ff3_q)
            begin
                lvl_q <= ff3_q;
            end
            rise_q <= (ff2_q == ff3_q) && ff3_q && !lvl_q;
            fall_q <= (ff2_q == ff3_q) && !ff3_q && lvl_q;
        end
    end

    assign lvl = lvl_q;
    assign rise = rise_q;
    assign fall = fall_q;

endmodule : sfr_sync

/* verilog/sfr_mem.sv */
// Byte memory with one write port and one registered read port.
// Assumes out-of-range reads may return all ones.
`timescale 1ns/1ns
module sfr_mem #(
    parameter int unsigned DEPTH = 32'h108,
    parameter int unsigned AW = 32'h9,
    parameter int unsigned DW = 32'h8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rd_q;

    always_ff @(posedge mclk)
    begin
        if (wr_en && (wr_addr < AW'(DEPTH)))
        begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_q <= '1;
        end
        else if (rd_addr < AW'(DEPTH))
        begin
            rd_q <= mem_q[rd_addr];
        end
        else
        begin
            rd_q <= '1;
        end
    end

    assign rd_data = rd_q;

endmodule : sfr_mem

/* verilog/sfr_read_core.sv */
// Read-command engine of a serial paged flash: pin sampling, command decode,
// and streaming of array, buffer or status bits on the serial output.
// Assumes mclk is many times faster than the serial clock and that program
// logic elsewhere fills the array and buffers through the load ports.
`timescale 1ns/1ns
module sfr_read_core
    import sfr_pkg::*;
#(
    parameter logic [2:0] DEV_INFO = 3'h5  // Arbitrary device information code
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial pins
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Device status from the program and compare logic
    input wire logic dev_ready,
    input wire logic cmp_diff,
    // Main array load port
    input wire logic arr_wr_en,
    input wire logic [sfr_pkg::ARR_AW-1:0] arr_wr_addr,
    input wire logic [sfr_pkg::DATA_W-1:0] arr_wr_data,
    // Buffer one load port
    input wire logic buf1_wr_en,
    input wire logic [sfr_pkg::BYTE_AW-1:0] buf1_wr_addr,
    input wire logic [sfr_pkg::DATA_W-1:0] buf1_wr_data,
    // Buffer two load port
    input wire logic buf2_wr_en,
    input wire logic [sfr_pkg::BYTE_AW-1:0] buf2_wr_addr,
    input wire logic [sfr_pkg::DATA_W-1:0] buf2_wr_data
);
    import sfr_pkg::*;

    logic [PIN_CNT-1:0] pin_raw;
    logic [PIN_CNT-1:0] pin_lvl;
    logic [PIN_CNT-1:0] pin_rise;
    logic [PIN_CNT-1:0] pin_fall;
    logic cs_lvl;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_lvl;

    sfr_state_e state_q;
    sfr_src_e src_q;
    sfr_src_e cur_src;
    logic spi_fam_q;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [31:0] sh_q;
    logic [31:0] sh_d;
    logic hdr_edge;

    logic [PAGE_AW-1:0] page_addr_q;
    logic [BYTE_AW-1:0] page_byte_addr_q;
    logic [BYTE_AW-1:0] buffer_byte_addr_q;
    logic [ARR_AW-1:0] arr_rd_addr;
    logic [DATA_W-1:0] arr_rd_data;
    logic [DATA_W-1:0] buf1_rd_data;
    logic [DATA_W-1:0] buf2_rd_data;
    logic [DATA_W-1:0] status_vec;
    logic [DATA_W-1:0] src_byte;

    logic out_edge;
    logic load;
    logic [3:0] bits_left_q;
    logic [6:0] shreg_q;
    logic so_q;
    logic so_oe_q;

    // Only the low seven opcode bits name the command
    function automatic sfr_src_e op_src(input logic [6:0] op);
        sfr_src_e s;
        s = SRC_NONE;
        case (op)
            OP_ARR_CONT: s = SRC_ARR;
            OP_PAGE: s = SRC_PAGE;
            OP_BUF1: s = SRC_BUF1;
            OP_BUF2: s = SRC_BUF2;
            OP_STATUS: s = SRC_STAT;
            default: s = SRC_NONE;
        endcase
        return s;
    endfunction : op_src

    function automatic logic [6:0] hdr_len(input sfr_src_e s);
        logic [6:0] n;
        n = HDR_ARR;
        case (s)
            SRC_ARR: n = HDR_ARR;
            SRC_PAGE: n = HDR_ARR;
            SRC_BUF1: n = HDR_BUF;
            SRC_BUF2: n = HDR_BUF;
            SRC_STAT: n = HDR_STAT;
            default: n = HDR_ARR;
        endcase
        return n;
    endfunction : hdr_len

    // Start addresses past the last byte wrap after one byte
    function automatic logic [8:0] next_byte(input logic [8:0] b, input logic [8:0] last);
        return (b >= last) ? 9'h000 : 9'(b + 9'h001);
    endfunction : next_byte

    function automatic logic [18:0] arr_index(input logic [9:0] pg, input logic [8:0] by);
        return 19'(19'(pg) * 19'(PAGE_BYTES)) + 19'(by);
    endfunction : arr_index

    // Pin samplers
    assign pin_raw[PIN_CS] = cs_b;
    assign pin_raw[PIN_SCK] = sck;
    assign pin_raw[PIN_SI] = si;

    for (genvar i = 0; i < PIN_CNT; i++)
    begin : g_pin
        sfr_sync #(
            .RST_VAL(PIN_RST_VAL[i])
        ) u_sync (
            .mclk(mclk),
            .rst_b(rst_b),
            .pin(pin_raw[i]),
            .lvl(pin_lvl[i]),
            .rise(pin_rise[i]),
            .fall(pin_fall[i])
        );
    end

    assign cs_lvl = pin_lvl[PIN_CS];
    assign cs_rise = pin_rise[PIN_CS];
    assign sck_rise = pin_rise[PIN_SCK];
    assign sck_fall = pin_fall[PIN_SCK];
    assign si_lvl = pin_lvl[PIN_SI];

    // Header shifting on rising serial clock edges
    assign hdr_edge = (state_q == ST_HDR) && sck_rise;
    assign cnt_d = 7'(cnt_q + 7'h01);
    assign sh_d = {sh_q[30:0], si_lvl};
    assign cur_src = (cnt_d == OPCODE_BITS) ? op_src(sh_d[6:0]) : src_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
        end
        else if (cs_lvl)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE: state_q <= ST_HDR;
                ST_HDR:
                begin
                    // An unknown opcode is judged only once all eight bits are in
                    if (hdr_edge && (cnt_d == OPCODE_BITS) && (cur_src == SRC_NONE))
                    begin
                        state_q <= ST_DISCARD;
                    end
                    else if (hdr_edge && (cnt_d == hdr_len(cur_src)))
                    begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: state_q <= ST_DATA;
                ST_DISCARD: state_q <= ST_DISCARD;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 7'h00;
            sh_q <= 32'h0000_0000;
        end
        else if (cs_lvl || (state_q == ST_IDLE))
        begin
            cnt_q <= 7'h00;
            sh_q <= 32'h0000_0000;
        end
        else if (hdr_edge)
        begin
            cnt_q <= cnt_d;
            sh_q <= sh_d;
        end
    end

    // Command source and clock family, taken from the opcode
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_q <= SRC_NONE;
            spi_fam_q <= 1'b1;
        end
        else if (hdr_edge && (cnt_d == OPCODE_BITS))
        begin
            src_q <= cur_src;
            spi_fam_q <= sh_d[OP_FAMILY_BIT];
        end
    end

    // Output edges: SPI family drives on falling edges, the other family on rising edges
    assign out_edge = (state_q == ST_DATA) && (spi_fam_q ? sck_fall : sck_rise);
    assign load = out_edge && (bits_left_q == 4'h0);

    // Address capture and advance
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            page_addr_q <= 10'h000;
            page_byte_addr_q <= 9'h000;
            buffer_byte_addr_q <= 9'h000;
        end
        else if (hdr_edge && (cnt_d == ADDR_DONE_BITS))
        begin
            page_addr_q <= sh_d[PAGE_LSB +: PAGE_AW];
            page_byte_addr_q <= sh_d[BYTE_LSB +: BYTE_AW];
            buffer_byte_addr_q <= sh_d[BYTE_LSB +: BYTE_AW];
        end
        else if (load)
        begin
            case (src_q)
                SRC_ARR:
                begin
                    page_byte_addr_q <= next_byte(page_byte_addr_q, PAGE_LAST_BYTE);
                    if (page_byte_addr_q >= PAGE_LAST_BYTE)
                    begin
                        page_addr_q <= (page_addr_q == LAST_PAGE) ? 10'h000 :
                            10'(page_addr_q + 10'h001);
                    end
                end
                SRC_PAGE: page_byte_addr_q <= next_byte(page_byte_addr_q, PAGE_LAST_BYTE);
                SRC_BUF1: buffer_byte_addr_q <= next_byte(buffer_byte_addr_q, BUF_LAST_BYTE);
                SRC_BUF2: buffer_byte_addr_q <= next_byte(buffer_byte_addr_q, BUF_LAST_BYTE);
                default: buffer_byte_addr_q <= buffer_byte_addr_q;
            endcase
        end
    end

    // Storage; reads never reach the buffer write ports
    assign arr_rd_addr = arr_index(page_addr_q, page_byte_addr_q);

    sfr_mem #(
        .DEPTH(ARR_DEPTH),
        .AW(ARR_AW),
        .DW(DATA_W)
    ) u_arr (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(arr_wr_en),
        .wr_addr(arr_wr_addr),
        .wr_data(arr_wr_data),
        .rd_addr(arr_rd_addr),
        .rd_data(arr_rd_data)
    );

    sfr_mem #(
        .DEPTH(BUF_BYTES),
        .AW(BYTE_AW),
        .DW(DATA_W)
    ) u_buf1 (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(buf1_wr_en),
        .wr_addr(buf1_wr_addr),
        .wr_data(buf1_wr_data),
        .rd_addr(buffer_byte_addr_q),
        .rd_data(buf1_rd_data)
    );

    sfr_mem #(
        .DEPTH(BUF_BYTES),
        .AW(BYTE_AW),
        .DW(DATA_W)
    ) u_buf2 (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(buf2_wr_en),
        .wr_addr(buf2_wr_addr),
        .wr_data(buf2_wr_data),
        .rd_addr(buffer_byte_addr_q),
        .rd_data(buf2_rd_data)
    );

    // Live status byte, sampled afresh at each bit 7
    always_comb
    begin
        status_vec = 8'h00;
        status_vec[ST_READY_BIT] = dev_ready;
        status_vec[ST_CMP_BIT] = cmp_diff;
        status_vec[ST_INFO_LSB +: 3] = DEV_INFO;
        status_vec[2:0] = ST_RSVD_VAL;
    end

    always_comb
    begin
        case (src_q)
            SRC_STAT: src_byte = status_vec;
            SRC_BUF1: src_byte = buf1_rd_data;
            SRC_BUF2: src_byte = buf2_rd_data;
            default: src_byte = arr_rd_data;
        endcase
    end

    // Output shifter
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bits_left_q <= 4'h0;
            shreg_q <= 7'h00;
            so_q <= 1'b0;
        end
        else if (state_q != ST_DATA)
        begin
            bits_left_q <= 4'h0;
            shreg_q <= 7'h00;
            so_q <= 1'b0;
        end
        else if (load)
        begin
            so_q <= src_byte[7];
            shreg_q <= src_byte[6:0];
            bits_left_q <= 4'h7;
        end
        else if (out_edge)
        begin
            so_q <= shreg_q[6];
            shreg_q <= {shreg_q[5:0], 1'b0};
            bits_left_q <= 4'(bits_left_q - 4'h1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            so_oe_q <= 1'b0;
        end
        else if (cs_lvl || (state_q != ST_DATA))
        begin
            so_oe_q <= 1'b0;
        end
        else if (out_edge)
        begin
            so_oe_q <= 1'b1;
        end
    end

    assign so = so_q;
    assign so_oe = so_oe_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_enter_data;
        (state_q == ST_HDR) ##1 (state_q == ST_DATA);
    endsequence

    sequence s_arr_page_end;
        load && (src_q == SRC_ARR) && (page_byte_addr_q == PAGE_LAST_BYTE);
    endsequence

    cs_release_a: assert property (cs_rise |=> (!so_oe_q && (state_q == ST_IDLE)))
        else $error("output still driven after select rose");
    hdr_hiz_a: assert property ((state_q == ST_HDR) || cs_lvl |=> !so_oe_q)
        else $error("output driven outside data phase");
    arr_hdr_len_a: assert property (s_enter_data |-> ((src_q != SRC_ARR) || (cnt_q == HDR_ARR)))
        else $error("array read header length wrong");
    page_hdr_len_a: assert property (s_enter_data |-> ((src_q != SRC_PAGE) || (cnt_q == HDR_ARR)))
        else $error("page read header length wrong");
    buf_hdr_len_a: assert property (s_enter_data |->
        (!((src_q == SRC_BUF1) || (src_q == SRC_BUF2)) || (cnt_q == HDR_BUF)))
        else $error("buffer read header length wrong");
    stat_hdr_len_a: assert property (s_enter_data |-> ((src_q != SRC_STAT) || (cnt_q == HDR_STAT)))
        else $error("status read header length wrong");
    page_cross_a: assert property (s_arr_page_end and (page_addr_q != LAST_PAGE) |=>
        ((page_byte_addr_q == 9'h000) && (page_addr_q == 10'($past(page_addr_q) + 10'h001))))
        else $error("continuous read did not cross to next page");
    arr_wrap_a: assert property (s_arr_page_end and (page_addr_q == LAST_PAGE) |=>
        ((page_byte_addr_q == 9'h000) && (page_addr_q == 10'h000)))
        else $error("continuous read did not wrap to page zero");
    page_wrap_a: assert property (load && (src_q == SRC_PAGE) && (page_byte_addr_q == PAGE_LAST_BYTE) |=>
        ((page_byte_addr_q == 9'h000) && $stable(page_addr_q)))
        else $error("page read left its page");
    buf_wrap_a: assert property (load && ((src_q == SRC_BUF1) || (src_q == SRC_BUF2)) &&
        (buffer_byte_addr_q == BUF_LAST_BYTE) |=> (buffer_byte_addr_q == 9'h000))
        else $error("buffer read did not wrap");
    msb_shift_a: assert property (out_edge && !load |=> (so_q == $past(shreg_q[6])))
        else $error("output bit order wrong");
    stat_fresh_a: assert property (load && (src_q == SRC_STAT) |=> (so_q == $past(dev_ready)))
        else $error("status bit 7 not freshly sampled");
    edge_family_a: assert property ((state_q == ST_DATA) && (spi_fam_q ? sck_rise : sck_fall) |=> $stable(so_q))
        else $error("output changed on wrong clock edge");

endmodule : sfr_read_core

/* sim/sfr_host.sv */
// Host model: serial master driving select, clock and data into the read engine.
// Assumes a 160 ns serial clock and that the caller waits for each frame to end.
`timescale 1ns/1ns
module sfr_host (
    // Serial pins
    output logic cs_b,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [7:0] got [8];
    int n_oe;

    initial
    begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        n_oe = 0;
    end

    // Output enable seen high where the pin must float
    task automatic oe_chk;
        if (so_oe !== 1'b0)
            n_oe++;
    endtask : oe_chk

    task automatic xfer(input logic [7:0] op, input logic [23:0] adr, input int nadr, input int ndum,
                        input int nb);
        logic [31:0] hdr;
        int i;
        hdr = {op, adr};
        sck <= 1'b0;
        #80;
        cs_b <= 1'b0;
        #80;
        for (i = 0; i < 8 + nadr + ndum; i++)
        begin
            sck <= 1'b0;
            si <= (i < 32) ? hdr[31-i] : ~si;
            #80;
            sck <= 1'b1;
            oe_chk();
            #80;
        end
        // Family with bit 7 set shifts on falls, the other on rises
        for (i = 0; i < nb * 8; i++)
        begin
            sck <= 1'b0;
            #80;
            if (op[7])
                got[i/8][7-i%8] = (so_oe === 1'b1) ? so : 1'bx;
            sck <= 1'b1;
            #80;
            if (!op[7])
                got[i/8][7-i%8] = (so_oe === 1'b1) ? so : 1'bx;
        end
        cs_b <= 1'b1;
        si <= ~si;
        #80;
        oe_chk();
    endtask : xfer
endmodule : sfr_host

/* sim/tb.sv */
// Self-checking bench for the read engine, with a byte model of array and buffers.
// Assumes the host model and the default device information code.
`timescale 1ns/1ns
module tb;
    import sfr_pkg::*;
    localparam logic [2:0] INFO = 3'h5;  // Arbitrary device information code
    logic mclk, rst_b, cs_b, sck, si, so, so_oe, dev_ready, cmp_diff;
    logic arr_wr_en, buf1_wr_en, buf2_wr_en;
    logic [18:0] wa;
    logic [7:0] wd;
    logic [7:0] marr [int];
    logic [7:0] mbuf [2][264];
    int n_fail, n_compared, j;

    sfr_read_core #(.DEV_INFO(INFO)) sfr_read_core_inst (.mclk, .rst_b, .cs_b, .sck, .si, .so, .so_oe,
        .dev_ready, .cmp_diff, .arr_wr_en, .arr_wr_addr(wa), .arr_wr_data(wd), .buf1_wr_en,
        .buf1_wr_addr(wa[8:0]), .buf1_wr_data(wd), .buf2_wr_en, .buf2_wr_addr(wa[8:0]),
        .buf2_wr_data(wd));
    sfr_host sfr_host_inst (.cs_b, .sck, .si, .so, .so_oe);

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task chk(input string nm, input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task finish_test;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // One byte into the array (w=0) or a buffer (w=1,2), mirrored in the model
    task ld(input int w, input int a);
        @(posedge mclk);
        arr_wr_en <= (w == 0);
        buf1_wr_en <= (w == 1);
        buf2_wr_en <= (w == 2);
        wa <= a[18:0];
        wd <= 8'($urandom);
        #1;
        if (w == 0)
            marr[a] = wd;
        else
            mbuf[w-1][a] = wd;
    endtask : ld

    task rd(input logic [7:0] op, input int pg, input int by, input int nb);
        int k;
        logic [6:0] o;
        logic [7:0] e;
        o = op[6:0];
        sfr_host_inst.xfer(op, {5'h00, pg[9:0], by[8:0]}, (o == OP_STATUS) ? 0 : 24,
            (o == OP_STATUS) ? 0 : (o == OP_ARR_CONT || o == OP_PAGE) ? 32 : 8, nb);
        for (k = 0; k < nb; k++)
        begin
            case (o)
                OP_ARR_CONT: e = marr[(pg * 264 + by + k) % ARR_DEPTH];
                OP_PAGE: e = marr[pg * 264 + (by + k) % 264];
                OP_BUF1: e = mbuf[0][(by + k) % 264];
                OP_BUF2: e = mbuf[1][(by + k) % 264];
                OP_STATUS: e = {dev_ready, cmp_diff, INFO, 3'h0};
                default: e = 8'hXX;
            endcase
            chk("serial byte", sfr_host_inst.got[k], e);
        end
    endtask : rd

    initial
    begin
        rst_b = 1'b0;
        dev_ready = 1'b1;
        cmp_diff = 1'b0;
        arr_wr_en = 1'b0;
        buf1_wr_en = 1'b0;
        buf2_wr_en = 1'b0;
        wa = 19'h00000;
        wd = 8'h00;
        n_fail = 0;
        n_compared = 0;
        void'($urandom(30167));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        for (j = 0; j < 4; j++)
        begin
            ld(0, 5 * 264 + j);
            ld(0, 5 * 264 + 260 + j);
            ld(0, 6 * 264 + j);
            ld(0, 1023 * 264 + 260 + j);
            ld(0, j);
        end
        for (j = 0; j < 264; j++)
        begin
            ld(1, j);
            ld(2, j);
        end
        @(posedge mclk);
        arr_wr_en <= 1'b0;
        buf1_wr_en <= 1'b0;
        buf2_wr_en <= 1'b0;
        for (j = 0; j < 4; j++)
        begin
            @(posedge mclk);
            dev_ready <= j[0];
            cmp_diff <= j[1];
            @(posedge mclk);
            rd(j[0] ? 8'hD7 : 8'h57, 0, 0, 2);
        end
        rd(8'h68, 5, 260, 8);
        rd(8'hE8, 1023, 260, 8);
        rd(8'h52, 5, 260, 8);
        rd(8'hD2, 5, 261, 7);
        rd(8'h54, 0, $urandom_range(263), 4);
        rd(8'hD4, 0, 262, 4);
        rd(8'h56, 0, $urandom_range(263), 4);
        rd(8'hD6, 0, 263, 3);
        rd(8'h12, 0, 0, 1);
        chk("enable outside data", 8'(sfr_host_inst.n_oe), 8'h00);
        finish_test();
    end

    initial
    begin
        // About twice the length of the whole scenario list
        #300000;
        n_fail++;
        finish_test();
    end
endmodule : tb
